/* logic/ecpp_port.v */
/*
 * extended-capabilities parallel port: host I/O registers, one shared FIFO,
 * forward and reverse interlocked handshakes, DMA request and service interrupt.
 * assumes host strobes io_wr/io_rd for one cycle on the clock; pins are asynchronous.
 */
`include "ecpp_defines.vh"

module ecpp_port #(
	parameter DEPTH = `ECPP_FIFO_DEPTH,
	parameter AW = 4
) (
	input wire clock,
	input wire rst,
	input wire [`ECPP_AW-1:0] io_addr,
	input wire io_wr,
	input wire io_rd,
	input wire [7:0] io_wdata,
	output reg [7:0] io_rdata,
	input wire dma_ack,
	input wire dma_tc,
	input wire [`ECPP_THR_W-1:0] write_threshold,
	input wire [`ECPP_THR_W-1:0] read_threshold,
	output reg port_dma_request,
	output reg irq,
	input wire [7:0] parallel_data_bus_in,
	output reg [7:0] parallel_data_bus_out,
	output reg parallel_data_bus_oe,
	output reg host_write_clock_n,
	output reg host_handshake_n,
	output reg direction_request_n,
	output reg protocol_select_n,
	input wire periph_data_valid_n,
	input wire periph_handshake,
	input wire reverse_confirm_n,
	input wire printer_online,
	input wire periph_error_n
);
	localparam S_IDLE = 7'h01;
	localparam S_FSET = 7'h02;
	localparam S_FSTB = 7'h04;
	localparam S_FREL = 7'h08;
	localparam S_RWAIT = 7'h10;
	localparam S_RPUSH = 7'h20;
	localparam S_RACK = 7'h40;

	function is_pio_mode;
		input [2:0] m;
		begin
			is_pio_mode = (m == `ECPP_MODE_SPP) | (m == `ECPP_MODE_BIDIR);
		end
	endfunction

	function is_queue_mode;
		input [2:0] m;
		begin
			is_queue_mode = (m == `ECPP_MODE_COMPAT_DATA_QUEUE) | (m == `ECPP_MODE_ECP) | (m == `ECPP_MODE_TEST);
		end
	endfunction

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	reg [12:0] pin_meta_q;
	reg [12:0] pin_sync_q;
	reg err_prev_q;
	wire valid_n_s;
	wire busy_s;
	wire confirm_n_s;
	wire online_s;
	wire err_n_s;
	wire [7:0] pd_in_s;

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_meta_q <= 13'h1fff;
			pin_sync_q <= 13'h1fff;
			err_prev_q <= 1'b1;
		end else begin
			pin_meta_q <= {parallel_data_bus_in, periph_data_valid_n, periph_handshake, reverse_confirm_n,
				printer_online, periph_error_n};
			pin_sync_q <= pin_meta_q;
			err_prev_q <= pin_sync_q[0];
		end
	end

	assign pd_in_s = pin_sync_q[12:5];
	assign valid_n_s = pin_sync_q[4];
	assign busy_s = pin_sync_q[3];
	assign confirm_n_s = pin_sync_q[2];
	assign online_s = pin_sync_q[1];
	assign err_n_s = pin_sync_q[0];

	// ************************************************************
	// registers and host access decode
	// ************************************************************
	reg [2:0] mode_q;
	reg nerr_q;
	reg dma_en_q;
	reg svc_q;
	reg [5:0] dcr_q;
	reg [7:0] data_q;
	reg [6:0] st_q;
	reg [7:0] pd_lat_q;
	reg cmd_q;
	wire dir;
	wire wr_data;
	wire wr_dcr;
	wire wr_ecr;
	wire wr_dq;
	wire wr_aq;
	wire rd_dq;
	wire ecp_mode;
	wire fwd_run;
	wire rev_run;
	wire flush;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [`ECPP_FIFO_WIDTH-1:0] fifo_out_data;
	wire [AW:0] fifo_cnt;
	wire [AW:0] fifo_free;
	wire eng_pop;
	wire eng_push;
	wire host_push;
	wire host_pop;
	wire [2:0] new_mode;
	wire mode_ok;
	wire svc_set;
	wire err_pulse;

	assign dir = dcr_q[`ECPP_DCR_DIR];
	assign ecp_mode = (mode_q == `ECPP_MODE_ECP);
	assign wr_data = io_wr & ~dma_ack & (io_addr == `ECPP_OFF_DATA);
	assign wr_dcr = io_wr & ~dma_ack & (io_addr == `ECPP_OFF_DCR);
	assign wr_ecr = io_wr & ~dma_ack & (io_addr == `ECPP_OFF_ECR);
	// a DMA write lands in the data/test/compatible queue whatever io_addr holds, but only in the queue modes
	assign wr_dq = io_wr & (dma_ack | (io_addr == `ECPP_OFF_DQ)) & is_queue_mode(mode_q);
	assign wr_aq = wr_data & ecp_mode;
	assign rd_dq = io_rd & (dma_ack | (io_addr == `ECPP_OFF_DQ))
		& (ecp_mode | (mode_q == `ECPP_MODE_TEST));

	// fifo only lives in the queue modes and starts flushed
	assign flush = ~is_queue_mode(mode_q);
	assign fwd_run = ~dir & (ecp_mode | (mode_q == `ECPP_MODE_COMPAT_DATA_QUEUE));
	assign rev_run = dir & ecp_mode & ~confirm_n_s;

	assign new_mode = io_wdata[`ECPP_ECR_MODE_HI:`ECPP_ECR_MODE_LO];
	assign mode_ok = is_pio_mode(mode_q) | is_pio_mode(new_mode);

	// ************************************************************
	// shared queue
	// ************************************************************
	assign eng_pop = (st_q == S_IDLE) & fwd_run & fifo_out_valid;
	assign eng_push = (st_q == S_RPUSH);
	// reverse engine has the write port while it holds a byte; host write then drops
	assign host_push = (wr_dq | wr_aq) & ~eng_push;
	assign host_pop = rd_dq & ~eng_pop;
	assign fifo_free = DEPTH[AW:0] - fifo_cnt;

	ecpp_fifo #(
		.WIDTH(`ECPP_FIFO_WIDTH),
		.DEPTH(DEPTH),
		.AW(AW)
	) u_fifo (
		.clock(clock),
		.rst(rst),
		.flush(flush),
		.in_valid(eng_push | host_push),
		.in_ready(fifo_in_ready),
		// address-queue bytes carry the command flag, data-queue bytes do not
		.in_data(eng_push ? {cmd_q, pd_lat_q} : {wr_aq, io_wdata}),
		.out_valid(fifo_out_valid),
		.out_ready(eng_pop | host_pop),
		.out_data(fifo_out_data),
		.count(fifo_cnt)
	);

	// ************************************************************
	// service flag and interrupts
	// ************************************************************
	assign svc_set = ~svc_q & is_queue_mode(mode_q) & (
		(dma_en_q & dma_tc) |
		(~dma_en_q & ~dir & (fifo_free >= {1'b0, write_threshold})) |
		(~dma_en_q & dir & (fifo_cnt >= {1'b0, read_threshold})));
	assign err_pulse = ecp_mode & ~nerr_q & err_prev_q & ~err_n_s;

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			mode_q <= `ECPP_MODE_SPP;
			nerr_q <= 1'b0;
			dma_en_q <= 1'b0;
			svc_q <= 1'b0;
			dcr_q <= `ECPP_DCR_RST;
			data_q <= `ECPP_DATA_RST;
		end else begin
			if (wr_ecr) begin
				if (mode_ok) begin
					mode_q <= new_mode;
				end
				nerr_q <= io_wdata[`ECPP_ECR_NERR];
				dma_en_q <= io_wdata[`ECPP_ECR_DMA];
			end
			// hardware set wins over a software clear in the same cycle
			if (svc_set) begin
				svc_q <= 1'b1;
			end else if (wr_ecr) begin
				svc_q <= io_wdata[`ECPP_ECR_SVC];
			end
			if (wr_dcr) begin
				dcr_q[4:0] <= io_wdata[4:0];
				if (mode_q == `ECPP_MODE_BIDIR) begin
					dcr_q[`ECPP_DCR_DIR] <= io_wdata[`ECPP_DCR_DIR];
				end
			end
			if (wr_data & is_pio_mode(mode_q)) begin
				data_q <= io_wdata;
			end
		end
	end

	// ************************************************************
	// handshake engine
	// ************************************************************
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			st_q <= S_IDLE;
			pd_lat_q <= 8'h00;
			cmd_q <= 1'b0;
		end else if (flush) begin
			st_q <= S_IDLE;
		end else begin
			case (st_q)
				S_IDLE: begin
					if (eng_pop) begin
						pd_lat_q <= fifo_out_data[7:0];
						// compatible mode never sends commands
						cmd_q <= fifo_out_data[8] & ecp_mode;
						st_q <= S_FSET;
					end else if (rev_run) begin
						st_q <= S_RWAIT;
					end
				end
				S_FSET: begin
					if (~busy_s) begin
						st_q <= S_FSTB;
					end
				end
				S_FSTB: begin
					if (busy_s) begin
						st_q <= S_FREL;
					end
				end
				S_FREL: begin
					if (~busy_s) begin
						st_q <= S_IDLE;
					end
				end
				S_RWAIT: begin
					if (~rev_run) begin
						st_q <= S_IDLE;
					end else if (~valid_n_s) begin
						pd_lat_q <= pd_in_s;
						cmd_q <= ~busy_s;
						st_q <= S_RPUSH;
					end
				end
				S_RPUSH: begin
					// a full queue stalls the peripheral: host_handshake_n stays high, so the next byte is not requested
					if (fifo_in_ready) begin
						st_q <= S_RACK;
					end
				end
				S_RACK: begin
					if (valid_n_s) begin
						st_q <= rev_run ? S_RWAIT : S_IDLE;
					end
				end
				default: begin
					st_q <= S_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// registered pins, requests and read data
	// ************************************************************
	reg [7:0] rdata_d;

	always @* begin
		rdata_d = 8'h00;
		case (io_addr)
			`ECPP_OFF_DATA: begin
				rdata_d = (mode_q == `ECPP_MODE_BIDIR) ? pd_in_s : data_q;
			end
			`ECPP_OFF_DSR: begin
				rdata_d = {~busy_s, valid_n_s, confirm_n_s, online_s, err_n_s, `ECPP_DSR_LOW};
			end
			`ECPP_OFF_DCR: begin
				rdata_d = {`ECPP_DCR_TOP, dcr_q};
			end
			`ECPP_OFF_DQ: begin
				if (mode_q == `ECPP_MODE_CFG) begin
					rdata_d = `ECPP_CFGA_VAL;
				end else begin
					rdata_d = fifo_out_data[7:0];
				end
			end
			`ECPP_OFF_CFGB: begin
				// compress bit reads zero: no hardware run-length compression
				rdata_d = {1'b0, irq, `ECPP_CFGB_LOW};
			end
			`ECPP_OFF_ECR: begin
				rdata_d = {mode_q, nerr_q, dma_en_q, svc_q, ~fifo_in_ready, ~fifo_out_valid};
			end
			default: begin
				rdata_d = 8'h00;
			end
		endcase
		if (dma_ack) begin
			rdata_d = fifo_out_data[7:0];
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			io_rdata <= 8'h00;
			port_dma_request <= 1'b0;
			irq <= 1'b0;
			parallel_data_bus_out <= 8'h00;
			parallel_data_bus_oe <= 1'b0;
			host_write_clock_n <= 1'b1;
			host_handshake_n <= 1'b1;
			direction_request_n <= 1'b1;
			protocol_select_n <= 1'b1;
		end else begin
			if (io_rd) begin
				io_rdata <= rdata_d;
			end
			port_dma_request <= dma_en_q & ~svc_q & ~svc_set & is_queue_mode(mode_q)
				& (dir ? fifo_out_valid : fifo_in_ready);
			irq <= svc_set | err_pulse;
			// drive the bus only forward, and in ECP only once the peripheral has released it
			parallel_data_bus_oe <= ~dir & (~ecp_mode | confirm_n_s);
			if (fwd_run) begin
				parallel_data_bus_out <= pd_lat_q;
				host_write_clock_n <= ~(st_q == S_FSTB);
				host_handshake_n <= ~cmd_q;
			end else if (ecp_mode & dir) begin
				parallel_data_bus_out <= data_q;
				host_write_clock_n <= 1'b1;
				host_handshake_n <= ~(st_q == S_RWAIT);
			end else begin
				parallel_data_bus_out <= data_q;
				host_write_clock_n <= ~dcr_q[`ECPP_DCR_STB];
				host_handshake_n <= ~dcr_q[`ECPP_DCR_AFD];
			end
			if (ecp_mode) begin
				direction_request_n <= ~dir;
				protocol_select_n <= 1'b1;
			end else begin
				direction_request_n <= dcr_q[`ECPP_DCR_INIT];
				protocol_select_n <= ~dcr_q[`ECPP_DCR_SELIN];
			end
		end
	end
endmodule // ecpp_port

/* logic/ecpp_defines.vh */
/*
 * constants of the extended-capabilities parallel port: register offsets,
 * mode encodings, field positions, reset values and fixed read values.
 * assumes a host I/O port that decodes the port's window down to 11 bits.
 */
`ifndef ECPP_DEFINES_VH
`define ECPP_DEFINES_VH

`define ECPP_AW 11
`define ECPP_OFF_DATA 11'h000
`define ECPP_OFF_DSR 11'h001
`define ECPP_OFF_DCR 11'h002
`define ECPP_OFF_DQ 11'h400
`define ECPP_OFF_CFGB 11'h401
`define ECPP_OFF_ECR 11'h402

`define ECPP_MODE_SPP 3'h0
`define ECPP_MODE_BIDIR 3'h1
`define ECPP_MODE_COMPAT_DATA_QUEUE 3'h2
`define ECPP_MODE_ECP 3'h3
`define ECPP_MODE_EPP 3'h4
`define ECPP_MODE_TEST 3'h6
`define ECPP_MODE_CFG 3'h7

`define ECPP_FIFO_DEPTH 16
`define ECPP_FIFO_WIDTH 9
`define ECPP_THR_W 4

`define ECPP_ECR_MODE_HI 7
`define ECPP_ECR_MODE_LO 5
`define ECPP_ECR_NERR 4
`define ECPP_ECR_DMA 3
`define ECPP_ECR_SVC 2

`define ECPP_DCR_DIR 5
`define ECPP_DCR_ACKIE 4
`define ECPP_DCR_SELIN 3
`define ECPP_DCR_INIT 2
`define ECPP_DCR_AFD 1
`define ECPP_DCR_STB 0

`define ECPP_DCR_RST 6'h00
`define ECPP_DATA_RST 8'h00
`define ECPP_CFGA_VAL 8'h10
`define ECPP_CFGB_LOW 6'h07
`define ECPP_DSR_LOW 3'h7
`define ECPP_DCR_TOP 2'h3

`endif

/* logic/ecpp_fifo.v */
/*
 * show-ahead FIFO with valid/ready on both sides, a flush and a fill count.
 * assumes one clock; flush wins over any push or pop in the same cycle.
 */
module ecpp_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clock,
	input wire rst,
	input wire flush,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data,
	output wire [AW:0] count
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;

	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data = mem_q[rd_ptr_q];
	assign count = cnt_q;
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always @(posedge clock) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else if (flush) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			if (push & ~pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop & ~push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule // ecpp_fifo

/* tb/ecpp_checker.sv */
/* pin and host-strobe checks for ecpp_port.
   bound to every instance; sees its ports only. */
module ecpp_checker #(
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clock,
	input wire rst,
	input wire io_rd,
	input wire [7:0] io_rdata,
	input wire dma_tc,
	input wire port_dma_request,
	input wire irq,
	input wire [7:0] parallel_data_bus_out,
	input wire parallel_data_bus_oe,
	input wire host_write_clock_n,
	input wire host_handshake_n,
	input wire periph_handshake
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ******
	// assertions
	// ******
	chk_irq_one_cycle: assert property (irq |=> !irq)
		else $error("irq wider than one cycle");
	chk_tc_raises_irq: assert property (dma_tc && port_dma_request |-> ##[1:2] irq)
		else $error("no irq after terminal count");
	chk_tc_stops_dma: assert property (dma_tc && port_dma_request |-> ##[1:2] !port_dma_request [*4])
		else $error("dma request kept after terminal count");
	// sync delay on the acknowledge means the strobe lags it by up to four edges
	chk_strobe_waits_ack: assert property (!host_write_clock_n && !periph_handshake |=> !host_write_clock_n)
		else $error("strobe released before acknowledge");
	chk_strobe_release: assert property ($rose(periph_handshake) && !host_write_clock_n |-> ##[1:4] host_write_clock_n)
		else $error("strobe not released after acknowledge");
	chk_strobe_drives: assert property (!host_write_clock_n |-> parallel_data_bus_oe)
		else $error("strobe without driven data");
	chk_strobe_data_hold: assert property (
		!host_write_clock_n |-> $stable(parallel_data_bus_out) && $stable(host_handshake_n))
		else $error("data or flag moved under strobe");
	chk_strobe_gap: assert property ($rose(host_write_clock_n) |-> host_write_clock_n [*4])
		else $error("strobe reasserted too soon");
	chk_rdata_holds: assert property (!$past(io_rd) |-> $stable(io_rdata))
		else $error("read data changed without a read");
endmodule // ecpp_checker
bind ecpp_port ecpp_checker #(.DEPTH(DEPTH), .AW(AW)) u_chk (.clock, .rst, .io_rd, .io_rdata, .dma_tc,
	.port_dma_request, .irq, .parallel_data_bus_out, .parallel_data_bus_oe, .host_write_clock_n,
	.host_handshake_n, .periph_handshake);

/* tb/ecpp_periph.sv */
/* peripheral model: takes forward bytes, sends tx_count reverse bytes.
   assumes the port's pins; undriven data lines toggle each cycle. */
module ecpp_periph (
	input wire clock,
	input wire [7:0] parallel_data_bus_out,
	input wire parallel_data_bus_oe,
	input wire host_write_clock_n,
	input wire host_handshake_n,
	input wire direction_request_n,
	input wire [3:0] slow,
	input wire hold,
	input wire [3:0] tx_count,
	output logic [7:0] parallel_data_bus_in,
	output logic periph_handshake,
	output logic periph_data_valid_n,
	output logic reverse_confirm_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] rx_log [0:63];
	int rx_n = 0;
	int tx_i = 0;
	logic drive = 1'b0;
	logic [7:0] rev_q = 8'h00;
	logic [7:0] last = 8'h00;
	always_comb parallel_data_bus_in = parallel_data_bus_oe ? parallel_data_bus_out : drive ? rev_q : ~last;
	always @(posedge clock) last <= parallel_data_bus_in;
	always @(posedge clock) reverse_confirm_n <= direction_request_n;
	initial begin
		periph_handshake = 1'b0;
		periph_data_valid_n = 1'b1;
		forever begin
			@(posedge clock);
			if (!host_write_clock_n && reverse_confirm_n) begin
				rx_log[rx_n] <= {~host_handshake_n, parallel_data_bus_in};
				rx_n <= rx_n + 1;
				repeat (slow) @(posedge clock);
				periph_handshake <= 1'b1;
				while (!host_write_clock_n) @(posedge clock);
				periph_handshake <= 1'b0;
			end else if (!reverse_confirm_n && !host_handshake_n && tx_i < tx_count) begin
				rev_q <= 8'h30 + tx_i[7:0];
				drive <= 1'b1;
				periph_handshake <= (tx_i != 1);
				@(posedge clock);
				periph_data_valid_n <= 1'b0;
				while (!host_handshake_n) @(posedge clock);
				periph_data_valid_n <= 1'b1;
				@(posedge clock);
				drive <= 1'b0;
				tx_i <= tx_i + 1;
			end else begin
				periph_handshake <= hold; // busy while stalled
			end
		end
	end
endmodule // ecpp_periph

/* tb/testbench.sv */
/* self-checking bench for ecpp_port.
   assumes ecpp_periph on the link and the bound checker. */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, rst, io_wr, io_rd, dma_ack, dma_tc, hold, periph_error_n, port_dma_request, irq;
	logic parallel_data_bus_oe, host_write_clock_n, host_handshake_n, direction_request_n, protocol_select_n;
	logic periph_data_valid_n, periph_handshake, reverse_confirm_n;
	logic [10:0] io_addr;
	logic [7:0] io_wdata, io_rdata, parallel_data_bus_in, parallel_data_bus_out;
	logic [3:0] slow, tx_count;
	int errors = 0, samples_checked = 0, cycles = 0, irqs = 0, base, irqb;
	logic [8:0] fwd [0:3] = '{9'h185, 9'h041, 9'h112, 9'h0c3};
	logic [37:0] rows [0:13] = '{
		{11'h002, 8'h2e, 11'h002, 8'hce}, {11'h000, 8'h5a, 11'h000, 8'h5a},
		{11'h400, 8'h77, 11'h402, 8'h01}, {11'h402, 8'h20, 11'h402, 8'h21},
		{11'h002, 8'h20, 11'h002, 8'he0}, {11'h002, 8'h00, 11'h002, 8'hc0},
		{11'h402, 8'he0, 11'h400, 8'h10}, {11'h402, 8'h60, 11'h401, 8'h07},
		{11'h005, 8'hff, 11'h402, 8'he1}, {11'h402, 8'h00, 11'h005, 8'h00},
		{11'h402, 8'hc4, 11'h402, 8'hc5}, {11'h400, 8'ha5, 11'h402, 8'hc4},
		{11'h005, 8'h00, 11'h400, 8'ha5}, {11'h402, 8'h00, 11'h402, 8'h01}};
	ecpp_port #(.DEPTH(16), .AW(4)) u_dut (.clock, .rst, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
		.dma_ack, .dma_tc, .write_threshold(4'h8), .read_threshold(4'h4), .port_dma_request, .irq,
		.parallel_data_bus_in, .parallel_data_bus_out, .parallel_data_bus_oe, .host_write_clock_n,
		.host_handshake_n, .direction_request_n, .protocol_select_n, .periph_data_valid_n,
		.periph_handshake, .reverse_confirm_n, .printer_online(1'b1), .periph_error_n);
	ecpp_periph u_per (.clock, .parallel_data_bus_out, .parallel_data_bus_oe, .host_write_clock_n,
		.host_handshake_n, .direction_request_n, .slow, .hold, .tx_count, .parallel_data_bus_in,
		.periph_handshake, .periph_data_valid_n, .reverse_confirm_n);
	// ******
	// clock, interrupt count, hang limit
	// ******
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock) begin
		irqs <= irqs + (irq === 1'b1);
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			$display("unexpected timeout: expected finish, seen %0d cycles", cycles);
			test_done;
		end
	end
	// ******
	// tasks
	// ******
	task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		@(posedge clock);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge clock);
		io_wr <= 1'b0;
	endtask
	task automatic dwr(input logic [7:0] d, input logic tc);
		@(posedge clock);
		io_wdata <= d;
		dma_tc <= tc;
		dma_ack <= 1'b1;
		io_wr <= 1'b1;
		@(posedge clock);
		dma_tc <= 1'b0;
		dma_ack <= 1'b0;
		io_wr <= 1'b0;
	endtask
	task automatic rdc(input logic [10:0] a, input logic [7:0] exp, input string what);
		@(posedge clock);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge clock);
		io_rd <= 1'b0;
		#1 check(what, {1'b0, exp}, {1'b0, io_rdata});
	endtask
	task automatic wait_rx(input int n);
		for (int k = 0; k < 3000 && u_per.rx_n < n; k++) @(posedge clock);
	endtask
	task automatic test_done;
		$display("comparisons %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ******
	// main sequence
	// ******
	initial begin
		{io_addr, io_wdata, io_wr, io_rd, dma_ack, dma_tc, hold, slow, tx_count} = '0;
		periph_error_n = 1'b1;
		rst = 1'b1;
		repeat (4) @(posedge clock);
		#1 check("oe in reset", 9'h000, {8'h00, parallel_data_bus_oe});
		check("strobe in reset", 9'h001, {8'h00, host_write_clock_n});
		@(posedge clock);
		rst <= 1'b0;
		foreach (rows[i]) begin
			wr(rows[i][37:27], rows[i][26:19]);
			rdc(rows[i][18:8], rows[i][7:0], "register row");
		end
		check("bytes outside queue modes", 9'h000, 9'(u_per.rx_n));
		$display("register rows done");
		slow <= 4'h3;
		wr(11'h402, 8'h64);
		repeat (8) @(posedge clock);
		foreach (fwd[i]) wr(fwd[i][8] ? 11'h000 : 11'h400, fwd[i][7:0]);
		wait_rx(4);
		foreach (fwd[i]) check("forward byte", fwd[i], u_per.rx_log[i]);
		check("mode select pin", 9'h001, {8'h00, protocol_select_n});
		check("reverse want pin", 9'h001, {8'h00, direction_request_n});
		$display("forward test done");
		slow <= 4'h0;
		hold <= 1'b1;
		repeat (4) @(posedge clock);
		base = u_per.rx_n;
		for (int i = 0; i < 18; i++) wr(11'h400, 8'h90 + i[7:0]);
		rdc(11'h402, 8'h66, "status when full");
		hold <= 1'b0;
		wait_rx(base + 17);
		repeat (20) @(posedge clock);
		check("bytes accepted", 9'd17, 9'(u_per.rx_n - base));
		check("last byte", 9'h0a0, u_per.rx_log[base + 16]);
		rdc(11'h402, 8'h65, "status drained");
		$display("fill test done");
		// nine queued bytes leave seven free, one short of the write threshold
		hold <= 1'b1;
		repeat (4) @(posedge clock);
		base = u_per.rx_n;
		for (int i = 0; i < 10; i++) wr(11'h400, 8'h40 + i[7:0]);
		irqb = irqs;
		wr(11'h402, 8'h60);
		repeat (8) @(posedge clock);
		check("service irq below threshold", 9'd0, 9'(irqs - irqb));
		hold <= 1'b0;
		wait_rx(base + 10);
		repeat (20) @(posedge clock);
		check("service irq at threshold", 9'd1, 9'(irqs - irqb));
		rdc(11'h402, 8'h65, "status after service");
		// compatible fifo mode: init high so the peripheral stays forward
		wr(11'h402, 8'h24);
		wr(11'h002, 8'h04);
		wr(11'h402, 8'h44);
		repeat (6) @(posedge clock);
		base = u_per.rx_n;
		wr(11'h000, 8'h3c);
		wr(11'h400, 8'h9c);
		wait_rx(base + 1);
		repeat (20) @(posedge clock);
		check("compat bytes", 9'd1, 9'(u_per.rx_n - base));
		check("compat byte", 9'h09c, u_per.rx_log[base]);
		$display("service and compat test done");
		wr(11'h402, 8'h20);
		wr(11'h002, 8'h20);
		irqb = irqs;
		wr(11'h402, 8'h60);
		tx_count <= 4'h4;
		for (int k = 0; k < 3000 && u_per.tx_i < 4; k++) @(posedge clock);
		repeat (10) @(posedge clock);
		check("reverse want pin", 9'h000, {8'h00, direction_request_n});
		check("data drive", 9'h000, {8'h00, parallel_data_bus_oe});
		rdc(11'h402, 8'h64, "reverse status");
		check("service irq", 9'd1, 9'(irqs - irqb));
		for (int i = 0; i < 4; i++) rdc(11'h400, 8'h30 + i[7:0], "reverse byte");
		rdc(11'h402, 8'h65, "reverse drained");
		$display("reverse test done");
		wr(11'h402, 8'h20);
		wr(11'h002, 8'h00);
		wr(11'h402, 8'h68);
		repeat (8) @(posedge clock);
		base = u_per.rx_n;
		irqb = irqs;
		for (int k = 0; k < 100 && port_dma_request !== 1'b1; k++) @(posedge clock);
		check("dma request", 9'h001, {8'h00, port_dma_request});
		for (int i = 0; i < 3; i++) dwr(8'hd0 + i[7:0], i == 2);
		repeat (4) @(posedge clock);
		check("request after tc", 9'h000, {8'h00, port_dma_request});
		check("tc irq", 9'd1, 9'(irqs - irqb));
		wait_rx(base + 3);
		for (int i = 0; i < 3; i++) check("dma byte", {1'b0, 8'hd0 + i[7:0]}, u_per.rx_log[base + i]);
		rdc(11'h402, 8'h6d, "status after tc");
		$display("dma test done");
		irqb = irqs;
		periph_error_n <= 1'b0;
		repeat (6) @(posedge clock);
		periph_error_n <= 1'b1;
		wr(11'h402, 8'h7c);
		repeat (4) @(posedge clock);
		periph_error_n <= 1'b0;
		repeat (6) @(posedge clock);
		periph_error_n <= 1'b1;
		check("error irqs", 9'd1, 9'(irqs - irqb));
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rdc(11'h402, 8'h01, "status after reset");
		$display("error and reset test done");
		test_done;
	end
endmodule // testbench
